/* File: sbs_pkg.sv */
package sbs_pkg;
	// array geometry
	localparam int ADDR_W  = 16;
	localparam int DATA_W  = 18;
	localparam int DEPTH   = 65536;
	localparam int LANE_W  = 9;
	localparam int BURST_W = 2;
	// burst counter step and reset values
	localparam logic [BURST_W-1:0] BURST_STEP = 2'h1;
	localparam logic [BURST_W-1:0] BURST_ZERO = 2'h0;
	localparam logic [ADDR_W-1:0]  ADDR_ZERO  = 16'h0000;
	localparam logic [DATA_W-1:0]  DATA_ZERO  = 18'h00000;
	// cycle kinds decoded from the sampled controls
	typedef enum logic [1:0] {
		SBS_IDLE,
		SBS_READ,
		SBS_WRITE
	} sbs_op_type;
endpackage

/* File: sbs_core.sv */
// Summary of operation
// - 64K words of 18 bits, 16-bit address
// - address, data, controls registered on clock edge
// - lower enable bits 0-8, upper 9-17
// - write self-timed from sampling edge
// - processor strobe forces read, new address
// - controller strobe reads or writes new address
// - chip enable sampled only at address load
// - advance low steps address before access
// - advance high repeats current address
// - burst wraps to starting address after four
// - two-bit counter on low address bits only
// - continue cycles write if any enable low
// - output enable ignored during writes
module sbs_core
	import sbs_pkg::*;
(
	input  wire logic              core_clk,                    // device clock
	input  wire logic              reset,                       // sync reset, high
	input  wire logic [ADDR_W-1:0] addr_in,                     // external address
	input  wire logic              processor_transfer_start_n,  // processor strobe
	input  wire logic              controller_transfer_start_n, // controller strobe
	input  wire logic              burst_advance_n,             // advance, low steps
	input  wire logic              lower_byte_write_n,          // lower lane write
	input  wire logic              upper_byte_write_n,          // upper lane write
	input  wire logic              chip_enable_n,               // chip enable
	input  wire logic              output_enable_n,             // output enable, sampled
	input  wire logic [DATA_W-1:0] data_bus_in,                 // pin level seen
	output logic      [DATA_W-1:0] data_bus_out,                // read data
	output logic      [DATA_W-1:0] data_bus_oe                  // high while driving
);

	////////////////////////////////////////////////////////////////////////////
	// input registers

	// all synchronous inputs pass one register, as the pins would
	logic [ADDR_W-1:0] addr_q,  addr_d;   // captured address
	logic [DATA_W-1:0] wdat_q,  wdat_d;   // captured write data
	logic              tsp_q,   tsp_d;    // processor strobe, low active
	logic              tsc_q,   tsc_d;    // controller strobe, low active
	logic              adv_q,   adv_d;    // advance, low active
	logic              lw_q,    lw_d;     // lower write, low active
	logic              uw_q,    uw_d;     // upper write, low active
	logic              ce_q,    ce_d;     // chip enable, low active
	logic              oe_q,    oe_d;     // output enable, low active

	// next values of the input stage
	always_comb begin
		addr_d = addr_in;
		wdat_d = data_bus_in;
		tsp_d  = processor_transfer_start_n;
		tsc_d  = controller_transfer_start_n;
		adv_d  = burst_advance_n;
		lw_d   = lower_byte_write_n;
		uw_d   = upper_byte_write_n;
		ce_d   = chip_enable_n;
		// output enable is sampled too, so outputs stay registered
		oe_d   = output_enable_n;
	end

	// register the input stage; strobes idle high after reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			addr_q <= ADDR_ZERO;
			wdat_q <= DATA_ZERO;
			tsp_q  <= 1'h1;
			tsc_q  <= 1'h1;
			adv_q  <= 1'h1;
			lw_q   <= 1'h1;
			uw_q   <= 1'h1;
			ce_q   <= 1'h1;
			oe_q   <= 1'h1;
		end else begin
			addr_q <= addr_d;
			wdat_q <= wdat_d;
			tsp_q  <= tsp_d;
			tsc_q  <= tsc_d;
			adv_q  <= adv_d;
			lw_q   <= lw_d;
			uw_q   <= uw_d;
			ce_q   <= ce_d;
			oe_q   <= oe_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// burst address and cycle decode

	logic [ADDR_W-1:BURST_W]  base_q,  base_d;   // upper bits as loaded
	logic [BURST_W-1:0]       start_q, start_d;  // loaded low bits
	logic [BURST_W-1:0]       cnt_q,   cnt_d;    // burst offset
	logic                     sel_q,   sel_d;    // chip selected
	logic                     load;              // strobe seen this cycle
	logic                     any_wr;            // a lane enable low
	logic [BURST_W-1:0]       low_bits;          // address low bits used
	logic [ADDR_W-1:0]        eff_addr;          // address of this access
	sbs_op_type               op;                // access kind this cycle

	// decode the sampled controls into this cycle's access
	always_comb begin
		load     = !tsp_q || !tsc_q;
		any_wr   = !lw_q || !uw_q;
		base_d   = base_q;
		start_d  = start_q;
		cnt_d    = cnt_q;
		sel_d    = sel_q;
		low_bits = start_q + cnt_q;
		eff_addr = {base_q, low_bits};
		op       = SBS_IDLE;
		// a strobe restarts the burst whatever was in flight
		if (load) begin
			sel_d   = !ce_q;
			base_d  = addr_q[ADDR_W-1:BURST_W];
			start_d = addr_q[BURST_W-1:0];
			cnt_d   = BURST_ZERO;
			eff_addr = addr_q;
			if (!ce_q) begin
				if (!tsp_q) begin
					op = SBS_READ;
				end else begin
					op = any_wr ? SBS_WRITE : SBS_READ;
				end
			end
		end else if (sel_q) begin
			if (!adv_q) begin
				cnt_d    = cnt_q + BURST_STEP;
				low_bits = start_q + cnt_d;
			end
			eff_addr = {base_q, low_bits};
			op = any_wr ? SBS_WRITE : SBS_READ;
		end
	end

	// register burst state
	always_ff @(posedge core_clk) begin
		if (reset) begin
			base_q  <= '0;
			start_q <= BURST_ZERO;
			cnt_q   <= BURST_ZERO;
			sel_q   <= 1'h0;
		end else begin
			base_q  <= base_d;
			start_q <= start_d;
			cnt_q   <= cnt_d;
			sel_q   <= sel_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// memory array and output drive

	// full array, not reset; contents are undefined at power-up
	// clearing every word would cost one cycle per word after each reset
	logic [DATA_W-1:0] mem [DEPTH];
	logic [DATA_W-1:0] rd_q, rd_d;     // output data register
	logic [DATA_W-1:0] oe_vec_q, oe_vec_d; // per-bit drive enable

	// write happens in the cycle it is decoded, no external pulse
	// each lane gated by its own enable
	always_ff @(posedge core_clk) begin
		if (op == SBS_WRITE) begin
			if (!lw_q) begin
				mem[eff_addr][LANE_W-1:0] <= wdat_q[LANE_W-1:0];
			end
			if (!uw_q) begin
				mem[eff_addr][DATA_W-1:LANE_W] <= wdat_q[DATA_W-1:LANE_W];
			end
		end
	end

	// limitation: the drive enable is registered, so a read holds the pins
	// for the whole cycle after it is decoded; a master that presents a
	// write two cycles after a read must first let that read go by, or
	// mask it with the output enable, else its write data meets our read
	// data on the pins and the array takes the wrong word
	// read data and drive enable for the pins
	always_comb begin
		rd_d     = rd_q;
		oe_vec_d = '0;
		if (op == SBS_READ) begin
			rd_d = mem[eff_addr];
			oe_vec_d = oe_q ? '0 : '1;
		end
	end

	// register outputs so pins switch cleanly on the clock
	always_ff @(posedge core_clk) begin
		if (reset) begin
			rd_q     <= DATA_ZERO;
			oe_vec_q <= DATA_ZERO;
		end else begin
			rd_q     <= rd_d;
			oe_vec_q <= oe_vec_d;
		end
	end

	assign data_bus_out = rd_q;
	assign data_bus_oe  = oe_vec_q;

	////////////////////////////////////////////////////////////////////////////
	// assertions
	// all checks look at the registered controls, one cycle after the pins,
	// and are held off while reset is high

	AST_DESEL: assert property (@(posedge core_clk) disable iff (reset)
		(load && ce_q) |-> op == SBS_IDLE)
		else $error("deselect did not block access");
	AST_TSP_READ: assert property (@(posedge core_clk) disable iff (reset)
		(!tsp_q && !ce_q) |-> op == SBS_READ)
		else $error("processor strobe not a read");
	AST_TSC_WR: assert property (@(posedge core_clk) disable iff (reset)
		(tsp_q && !tsc_q && !ce_q && any_wr) |-> op == SBS_WRITE)
		else $error("controller write not taken");
	AST_ADV: assert property (@(posedge core_clk) disable iff (reset)
		(!load && sel_q && !adv_q) |=> cnt_q == $past(cnt_q) + BURST_STEP)
		else $error("advance did not step counter");
	AST_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		(!load && adv_q) |=> $stable(cnt_q))
		else $error("suspend moved counter");
	AST_UPPER: assert property (@(posedge core_clk) disable iff (reset)
		!load |=> $stable(base_q))
		else $error("upper address changed in burst");
	AST_NODRV_WR: assert property (@(posedge core_clk) disable iff (reset)
		(op == SBS_WRITE) |=> data_bus_oe == DATA_ZERO)
		else $error("bus driven after write");
	AST_DRV_RD: assert property (@(posedge core_clk) disable iff (reset)
		(op == SBS_READ && !oe_q) |=> data_bus_oe != DATA_ZERO)
		else $error("enabled read not driven");
	AST_WRAP: assert property (@(posedge core_clk) disable iff (reset)
		(!load && sel_q && !adv_q)[*4] |=> cnt_q == $past(cnt_q, 4))
		else $error("burst did not wrap");

	// data path: what lands in the array and what comes back out
	// lower lane write
	AST_WR_LOW: assert property (@(posedge core_clk) disable iff (reset)
		(op == SBS_WRITE && !lw_q) |=>
		mem[$past(eff_addr)][LANE_W-1:0] == $past(wdat_q[LANE_W-1:0]))
		else $error("lower lane not written");
	AST_WR_UP: assert property (@(posedge core_clk) disable iff (reset)
		(op == SBS_WRITE && !uw_q) |=>
		mem[$past(eff_addr)][DATA_W-1:LANE_W] == $past(wdat_q[DATA_W-1:LANE_W]))
		else $error("upper lane not written");
	AST_RD_DATA: assert property (@(posedge core_clk) disable iff (reset)
		(op == SBS_READ) |=> data_bus_out == $past(mem[eff_addr]))
		else $error("read data differs from array");

	// addressing: base load, linear step, suspend
	// base and start loaded
	AST_BASE_LOAD: assert property (@(posedge core_clk) disable iff (reset)
		(load && !ce_q) |=> base_q == $past(addr_q[ADDR_W-1:BURST_W])
		&& start_q == $past(addr_q[BURST_W-1:0]) && cnt_q == BURST_ZERO)
		else $error("burst base not loaded");
	AST_STEP_ORDER: assert property (@(posedge core_clk) disable iff (reset)
		(!load && sel_q && !adv_q) |-> eff_addr[BURST_W-1:0] == start_q + cnt_q + BURST_STEP
		&& eff_addr[ADDR_W-1:BURST_W] == base_q)
		else $error("burst step out of order");
	AST_SUSP_ADDR: assert property (@(posedge core_clk) disable iff (reset)
		(!load && sel_q && adv_q) |->
		eff_addr[BURST_W-1:0] == start_q + cnt_q)
		else $error("suspend moved address");

	// operation kind and pin drive
	// continue writes on lane
	AST_CONT_WR: assert property (@(posedge core_clk) disable iff (reset)
		(!load && sel_q && (!lw_q || !uw_q)) |-> op == SBS_WRITE)
		else $error("continue write not taken");
	AST_CONT_RD: assert property (@(posedge core_clk) disable iff (reset)
		(!load && sel_q && lw_q && uw_q) |-> op == SBS_READ)
		else $error("continue read not taken");
	AST_OE_MASK: assert property (@(posedge core_clk) disable iff (reset)
		(op == SBS_READ && oe_q) |=> data_bus_oe == DATA_ZERO)
		else $error("masked read drove the bus");
	AST_IDLE_NODRV: assert property (@(posedge core_clk) disable iff (reset)
		(op == SBS_IDLE) |=> data_bus_oe == DATA_ZERO)
		else $error("idle cycle drove the bus");

	// cover points for the main scenarios
	COV_BURST: cover property (@(posedge core_clk) (!tsc_q && !ce_q) ##1 (!load && !adv_q)[*3]);
	COV_TSP_WR: cover property (@(posedge core_clk) (!tsp_q && !ce_q) ##1 (op == SBS_WRITE));
	COV_WAIT: cover property (@(posedge core_clk) (sel_q && !load && adv_q));
	// full wrap, and a deselecting strobe
	COV_WRAP: cover property (@(posedge core_clk) (!load && sel_q && !adv_q)[*4]);
	COV_DESEL: cover property (@(posedge core_clk) (load && ce_q));
endmodule

/* File: sbs_bus_model.sv */
////////////////////////////////////////
module sbs_bus_model
	import sbs_pkg::*;
(
	core_clk, // clock
	drive,    // master drives data
	wdata,    // master write data
	dev_out,  // device read data
	dev_oe,   // device drive enable
	pin       // resolved pin level
);
	timeunit 1ns;
	timeprecision 1ps;
	input  wire logic              core_clk;
	input  wire logic              drive;
	input  wire logic [DATA_W-1:0] wdata;
	input  wire logic [DATA_W-1:0] dev_oe;
	input  wire logic [DATA_W-1:0] dev_out;
	output logic      [DATA_W-1:0] pin;
	logic [DATA_W-1:0] last_q = '0; // previous pin level
	// data only with write
	// floating bus flips each cycle so stale data never passes
	assign pin = (dev_oe & dev_out) | (~dev_oe & (drive ? wdata : ~last_q));
	always @(posedge core_clk) begin
		last_q <= pin;
	end
endmodule

/* File: tb_sync_burst_sram_core.sv */
////////////////////////////////////////
module tb_sync_burst_sram_core;
	import sbs_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ctl bits: proc, ctrl, advance, lower, upper, enable (all low active)
	typedef struct packed {
		logic [5:0]        ctl; // control pins
		logic [ADDR_W-1:0] ad;  // address
		logic [DATA_W-1:0] wd;  // write data
		logic              rd;  // read expected
		logic [DATA_W-1:0] ex;  // expected read data
	} sbs_row_type;
	logic              core_clk = 1'h0; // clock
	logic              reset = 1'h1;    // sync reset
	logic [5:0]        ctl = 6'h3f;     // control pins
	logic [ADDR_W-1:0] addr = '0;       // address
	logic [DATA_W-1:0] wd = '0;         // write data
	logic              oe_n = 1'h0;     // output enable
	logic [DATA_W-1:0] bus;             // resolved pins
	logic [DATA_W-1:0] dout;            // read data
	logic [DATA_W-1:0] doe;             // drive enable
	int                err_count = 0;   // mismatches
	int                cmp_count = 0;   // comparisons
	int                cyc = 0;         // cycle count
	sbs_row_type       rows [30];       // stimulus table
	always #5 core_clk = ~core_clk;
	sbs_core uut (.core_clk(core_clk), .reset(reset), .addr_in(addr),
		.processor_transfer_start_n(ctl[5]), .controller_transfer_start_n(ctl[4]),
		.burst_advance_n(ctl[3]), .lower_byte_write_n(ctl[2]),
		.upper_byte_write_n(ctl[1]), .chip_enable_n(ctl[0]),
		.output_enable_n(oe_n), .data_bus_in(bus), .data_bus_out(dout),
		.data_bus_oe(doe));
	sbs_bus_model model (.core_clk(core_clk), .drive(~(ctl[2] & ctl[1]) & ctl[5]),
		.wdata(wd), .dev_out(dout), .dev_oe(doe), .pin(bus));
	task chk(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			err_count++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task finish_test;
		if (err_count == 0 && cmp_count > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// hang guard, run needs about 50 cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 300) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		// master keeps enable valid on strobes, writes after proc read
		// a write never comes two rows after a read: that read still drives the pins
		rows = '{'{6'h28, 16'h1232, 18'h12345, 1'h0, 18'h0},
			'{6'h30, 16'h0, 18'h0abcd, 1'h0, 18'h0},
			'{6'h30, 16'h0, 18'h2aaaa, 1'h0, 18'h0},
			'{6'h30, 16'h0, 18'h15555, 1'h0, 18'h0},
			'{6'h2e, 16'h1232, 18'h0, 1'h1, 18'h12345},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h0abcd},
			'{6'h3e, 16'h0, 18'h0, 1'h1, 18'h0abcd},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h2aaaa},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h15555},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h12345},
			'{6'h2f, 16'h1232, 18'h0, 1'h0, 18'h0},
			'{6'h0a, 16'h1231, 18'h0, 1'h1, 18'h15555},
			'{6'h3a, 16'h0, 18'h0, 1'h0, 18'h0},
			'{6'h2e, 16'h1231, 18'h0, 1'h1, 18'h15400},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h12345},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h0abcd},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h2aaaa},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h15400},
			'{6'h2f, 16'h1232, 18'h0, 1'h0, 18'h0},
			'{6'h36, 16'h0, 18'h0, 1'h0, 18'h0},
			'{6'h28, 16'h12f3, 18'h00111, 1'h0, 18'h0},
			'{6'h28, 16'h12f0, 18'h00222, 1'h0, 18'h0},
			'{6'h2e, 16'h12f3, 18'h0, 1'h1, 18'h00111},
			'{6'h36, 16'h0, 18'h0, 1'h1, 18'h00222},
			'{6'h1f, 16'h1232, 18'h0, 1'h0, 18'h0},
			'{6'h36, 16'h0, 18'h0, 1'h0, 18'h0},
			'{6'h2c, 16'h12f0, 18'h3ffff, 1'h0, 18'h0},
			'{6'h2e, 16'h12f0, 18'h0, 1'h1, 18'h3fe22},
			'{6'h2f, 16'h1232, 18'h0, 1'h0, 18'h0},
			'{6'h36, 16'h0, 18'h0, 1'h0, 18'h0}};
		repeat (8) @(negedge core_clk);
		chk(doe, '0, "drive enable in reset");
		reset = 1'h0;
		// result of each row shows two cycles after it is presented
		// two extra passes let the last two rows be checked too
		for (int j = 0; j < 32; j++) begin
			if (j < 30) begin
				{ctl, addr, wd} = {rows[j].ctl, rows[j].ad, rows[j].wd};
			end
			if (j > 1) begin
				chk(doe, {DATA_W{rows[j-2].rd}}, "drive enable");
				if (rows[j-2].rd) chk(dout, rows[j-2].ex, "read data");
			end
			@(negedge core_clk);
		end
		// output enable high keeps pins released on a read
		oe_n = 1'h1;
		{ctl, addr} = {6'h2e, 16'h1232};
		@(negedge core_clk);
		ctl = 6'h2f;
		@(negedge core_clk);
		chk(doe, '0, "drive enable masked");
		chk(dout, 18'h12345, "masked read data");
		// reset in mid read cancels the answer
		oe_n = 1'h0;
		ctl = 6'h2e;
		@(negedge core_clk);
		reset = 1'h1;
		ctl = 6'h3f;
		@(negedge core_clk);
		chk(doe, '0, "drive enable after reset");
		chk(dout, '0, "read data after reset");
		// second release: the array keeps its contents through reset
		reset = 1'h0;
		ctl = 6'h2e;
		@(negedge core_clk);
		ctl = 6'h2f;
		@(negedge core_clk);
		chk(doe, '1, "drive enable after release");
		chk(dout, 18'h12345, "read data after release");
		finish_test();
	end
endmodule
